// ### sjp_pin_ctrl.sv
// Shared scan pin and probe pin control, test clock and core clock domains
`timescale 1ns/1ps
`default_nettype none
`include "sjp_regs.svh"

module sjp_pin_ctrl (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Test clock domain pins
    input wire logic testClk,
    input wire logic modeSel,
    // One-time settings
    input wire logic fuseDedicated,
    input wire logic fuseProbeDisable,
    // Shared scan pins, index 0 test clock, 1 data in, 2 data out
    input wire sjp_pkg::sjp_pins_t sharedIn,
    output logic [`SJP_PIN_CNT-1:0] sharedOut,
    output logic [`SJP_PIN_CNT-1:0] sharedOe,
    // User side of the shared pins
    input wire sjp_pkg::sjp_pins_t userOut,
    input wire sjp_pkg::sjp_pins_t userOe,
    output logic [`SJP_PIN_CNT-1:0] userIn,
    // Probe pins
    output logic probeOutA,
    output logic probeOeA,
    output logic probeOutB,
    output logic probeOeB,
    input wire logic userProbeOutA,
    input wire logic userProbeOeA,
    input wire logic userProbeOutB,
    input wire logic userProbeOeB,
    // Observed design nodes
    input wire sjp_pkg::sjp_nodes_t probeNodes,
    // Status
    output logic scanActive
);
    import sjp_pkg::*;

    // ****************************************
    // Test clock domain
    // ****************************************
    sjp_tap_e tapState;
    sjp_tap_e next_tapState;
    logic dedicatedTck;
    logic testActive;
    sjp_selword_t shiftWord;
    sjp_selword_t heldWord;
    logic heldToggle;
    logic irBit;

    sjp_sync #(.WIDTH(1)) u_syncDedTck (
        .clk(testClk),
        .reset_n(reset_n),
        .asyncIn(fuseDedicated),
        .syncOut(dedicatedTck)
    );

    always_comb begin
        unique case (tapState)
            TestLogicReset: next_tapState = modeSel ? TestLogicReset : RunIdle;
            RunIdle: next_tapState = modeSel ? SelectDr : RunIdle;
            SelectDr: next_tapState = modeSel ? SelectIr : CaptureDr;
            CaptureDr: next_tapState = modeSel ? Exit1Dr : ShiftDr;
            ShiftDr: next_tapState = modeSel ? Exit1Dr : ShiftDr;
            Exit1Dr: next_tapState = modeSel ? UpdateDr : PauseDr;
            PauseDr: next_tapState = modeSel ? Exit2Dr : PauseDr;
            Exit2Dr: next_tapState = modeSel ? UpdateDr : ShiftDr;
            UpdateDr: next_tapState = modeSel ? SelectDr : RunIdle;
            SelectIr: next_tapState = modeSel ? TestLogicReset : CaptureIr;
            CaptureIr: next_tapState = modeSel ? Exit1Ir : ShiftIr;
            ShiftIr: next_tapState = modeSel ? Exit1Ir : ShiftIr;
            Exit1Ir: next_tapState = modeSel ? UpdateIr : PauseIr;
            PauseIr: next_tapState = modeSel ? Exit2Ir : PauseIr;
            Exit2Ir: next_tapState = modeSel ? UpdateIr : ShiftIr;
            UpdateIr: next_tapState = modeSel ? SelectDr : RunIdle;
        endcase
    end

    always_ff @(posedge testClk or negedge reset_n) begin
        if (!reset_n) begin
            tapState <= TestLogicReset;
        end else begin
            tapState <= next_tapState;
        end
    end

    // Flag set by mode select low, cleared only at logic reset
    always_ff @(posedge testClk or negedge reset_n) begin
        if (!reset_n) begin
            testActive <= 1'b0;
        end else if (!modeSel) begin
            testActive <= 1'b1;
        end else if (next_tapState == TestLogicReset) begin
            testActive <= 1'b0;
        end
    end

    // Probe selection shift path from the data-in pin
    always_ff @(posedge testClk or negedge reset_n) begin
        if (!reset_n) begin
            shiftWord <= `SJP_SELWORD_RST;
            irBit <= 1'b0;
        end else begin
            if (tapState == CaptureDr) begin
                shiftWord <= heldWord;
            end else if (tapState == ShiftDr) begin
                shiftWord <= {sharedIn[`SJP_PIN_TDI], shiftWord[`SJP_SELWORD_W-1:1]};
            end
            if (tapState == ShiftIr) begin
                irBit <= sharedIn[`SJP_PIN_TDI];
            end
        end
    end

    // Held word stays stable between toggles for the core to pick up
    always_ff @(posedge testClk or negedge reset_n) begin
        if (!reset_n) begin
            heldWord <= `SJP_SELWORD_RST;
            heldToggle <= 1'b0;
        end else if (tapState == TestLogicReset && heldWord != `SJP_SELWORD_RST) begin
            heldWord <= `SJP_SELWORD_RST;
            heldToggle <= ~heldToggle;
        end else if (tapState == UpdateDr) begin
            heldWord <= shiftWord;
            heldToggle <= ~heldToggle;
        end
    end

    logic tckScan;
    logic tckShifting;
    logic tckTdoBit;
    assign tckScan = testActive | dedicatedTck;
    assign tckShifting = (tapState == ShiftDr) || (tapState == ShiftIr);
    assign tckTdoBit = (tapState == ShiftIr) ? irBit : shiftWord[0];

    // ****************************************
    // Crossing into the core domain
    // ****************************************
    logic [3:0] xferSync;
    logic [`SJP_PIN_CNT-1:0] pinSync;
    logic [1:0] fuseSync;
    logic toggleSeen;
    logic coreScan;
    logic coreShifting;
    logic coreTdoBit;
    logic coreDedicated;
    logic coreProbeOff;
    sjp_selword_t probeSel;

    sjp_sync #(.WIDTH(4)) u_syncXfer (
        .clk(core_clk),
        .reset_n(reset_n),
        .asyncIn({heldToggle, tckTdoBit, tckShifting, tckScan}),
        .syncOut(xferSync)
    );

    sjp_sync #(.WIDTH(`SJP_PIN_CNT)) u_syncPins (
        .clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(sharedIn),
        .syncOut(pinSync)
    );

    sjp_sync #(.WIDTH(2)) u_syncFuse (
        .clk(core_clk),
        .reset_n(reset_n),
        .asyncIn({fuseProbeDisable, fuseDedicated}),
        .syncOut(fuseSync)
    );

    assign coreDedicated = fuseSync[0];
    assign coreProbeOff = fuseSync[1];
    assign coreScan = xferSync[0] | coreDedicated;
    assign coreShifting = xferSync[1];
    assign coreTdoBit = xferSync[2];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            toggleSeen <= 1'b0;
            probeSel <= `SJP_SELWORD_RST;
        end else if (xferSync[3] != toggleSeen) begin
            toggleSeen <= xferSync[3];
            probeSel <= heldWord;
        end
    end

    // ****************************************
    // Shared pin multiplexing
    // ****************************************
    function automatic logic scanDrives(input int idx, input logic shifting);
        scanDrives = (idx == `SJP_PIN_TDO) && shifting;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < `SJP_PIN_CNT; gi++) begin : g_pin
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sharedOut[gi] <= 1'b0;
                    sharedOe[gi] <= 1'b0;
                    userIn[gi] <= 1'b0;
                end else if (coreScan) begin
                    sharedOut[gi] <= (gi == `SJP_PIN_TDO) ? coreTdoBit : 1'b0;
                    sharedOe[gi] <= scanDrives(gi, coreShifting);
                    userIn[gi] <= 1'b0;
                end else begin
                    sharedOut[gi] <= userOut[gi];
                    sharedOe[gi] <= userOe[gi];
                    userIn[gi] <= pinSync[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // Probe pins
    // ****************************************
    function automatic logic pickNode(input sjp_nodes_t nodes, input logic [`SJP_SEL_W-1:0] sel);
        pickNode = nodes[sel];
    endfunction

    logic probeOn;
    assign probeOn = probeSel[`SJP_SEL_EN_BIT] && !coreProbeOff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            probeOutA <= 1'b0;
            probeOeA <= 1'b0;
        end else if (probeOn) begin
            probeOutA <= pickNode(probeNodes, probeSel[`SJP_SEL_A_LSB +: `SJP_SEL_W]);
            probeOeA <= 1'b1;
        end else begin
            probeOutA <= userProbeOutA;
            probeOeA <= userProbeOeA;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            probeOutB <= 1'b0;
            probeOeB <= 1'b0;
        end else if (probeOn) begin
            probeOutB <= pickNode(probeNodes, probeSel[`SJP_SEL_B_LSB +: `SJP_SEL_W]);
            probeOeB <= 1'b1;
        end else begin
            probeOutB <= userProbeOutB;
            probeOeB <= userProbeOeB;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            scanActive <= 1'b0;
        end else begin
            scanActive <= coreScan;
        end
    end
endmodule

`default_nettype wire

// ### sjp_pin_ctrl_props.sv
// Assertion checker for the shared scan and probe pin control
`timescale 1ns/1ps
`default_nettype none
module sjp_pin_ctrl_chk (
    // Clock, reset and settings
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic fuseDedicated,
    input wire logic fuseProbeDisable,
    // Shared scan pins and their user side
    input wire sjp_pkg::sjp_pins_t sharedIn,
    input wire sjp_pkg::sjp_pins_t userOut,
    input wire sjp_pkg::sjp_pins_t userOe,
    input wire logic [2:0] sharedOut,
    input wire logic [2:0] sharedOe,
    input wire logic [2:0] userIn,
    // Probe pins and their user side
    input wire logic probeOutA,
    input wire logic probeOeA,
    input wire logic probeOutB,
    input wire logic probeOeB,
    input wire logic userProbeOutA,
    input wire logic userProbeOeA,
    input wire logic userProbeOutB,
    input wire logic userProbeOeB,
    // Status
    input wire logic scanActive
);
    import sjp_pkg::*;
    wire [3:0] probe_out_b = {probeOeB, probeOutB, probeOeA, probeOutA};
    wire [3:0] uprb = {userProbeOeB, userProbeOutB, userProbeOeA, userProbeOutA};
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    a_user_pin_follow: assert property (
        (!scanActive && !fuseDedicated)[*6] |-> $past(sharedOut, 3) == $past(userOut, 4)
        && $past(sharedOe, 3) == $past(userOe, 4)) else $error("user drive lost");
    a_scan_pins_in: assert property (
        scanActive[*6] |-> ($past(sharedOe, 3) & 3'h3) == 3'h0) else $error("scan pin driven");
    a_scan_user_in: assert property (
        scanActive[*6] |-> $past(userIn, 3) == 3'h0) else $error("pin data leaks");
    a_user_in_sync: assert property (
        (!scanActive)[*8] |-> $past(userIn, 2) == $past(sharedIn, 5)) else $error("user input");
    a_ded_scan_on: assert property (
        fuseDedicated[*5] |-> scanActive) else $error("dedicated not scan");
    a_ded_never_free: assert property (
        $fell(scanActive) |-> !fuseDedicated) else $error("dedicated pins released");
    a_probe_secure: assert property (
        fuseProbeDisable[*5] |-> probe_out_b == $past(uprb)) else $error("probe shows node");
    a_probe_user: assert property (
        (!scanActive)[*8] |-> $past(probe_out_b, 3) == $past(uprb, 4)) else $error("probe not user");
endmodule
bind sjp_pin_ctrl sjp_pin_ctrl_chk i_sjp_pin_ctrl_chk(.*);
`default_nettype wire

// ### sjp_pkg.sv
// Types for the shared scan and probe pin control block
`include "sjp_regs.svh"

package sjp_pkg;
    typedef enum logic [3:0] {
        TestLogicReset, RunIdle, SelectDr, CaptureDr, ShiftDr, Exit1Dr, PauseDr,
        Exit2Dr, UpdateDr, SelectIr, CaptureIr, ShiftIr, Exit1Ir, PauseIr,
        Exit2Ir, UpdateIr
    } sjp_tap_e;

    typedef logic [`SJP_SELWORD_W-1:0] sjp_selword_t;
    typedef logic [`SJP_NODE_CNT-1:0] sjp_nodes_t;
    typedef logic [`SJP_PIN_CNT-1:0] sjp_pins_t;
endpackage

// ### sjp_regs.svh
// Constants for the shared scan and probe pin control block
`ifndef SJP_REGS_SVH
`define SJP_REGS_SVH

// ****************************************
// Pin indices of the shared scan pins
// ****************************************
`define SJP_PIN_CNT 3
`define SJP_PIN_TCK 0
`define SJP_PIN_TDI 1
`define SJP_PIN_TDO 2

// ****************************************
// Probe selection word layout
// ****************************************
`define SJP_NODE_CNT 16
`define SJP_SEL_W 4
`define SJP_SEL_A_LSB 0
`define SJP_SEL_B_LSB 4
`define SJP_SEL_EN_BIT 8
`define SJP_SELWORD_W 9

// ****************************************
// Reset value and synchroniser stage count
// ****************************************
`define SJP_SELWORD_RST 9'h000
`define SJP_SYNC_STAGES 2

`endif

// ### sjp_sync.sv
// Multi-bit two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none

module sjp_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

`default_nettype wire

// ### sjp_tester.sv
// Scan tester model driving test clock, mode select and data-in pins
`timescale 1ns/1ps
`default_nettype none
module sjp_tester (
    output logic testClk,
    output logic modeSel,
    output logic tdi,
    output logic inFrame,
    input wire logic [2:0] sharedOut,
    input wire logic [2:0] sharedOe
);
    logic tckFree = 0;
    initial begin
        testClk = 0;
        modeSel = 1;
        tdi = 0;
        inFrame = 0;
        #0.2;
        forever #24 tckFree = ~tckFree;
    end
    // Clock only pulses inside steps, so it idles low between frames
    always @(negedge tckFree) testClk <= 1'b0;
    task automatic step(input logic m, input logic d, output logic o);
        @(negedge tckFree);
        inFrame = 1;
        modeSel = m;
        tdi = d;
        @(posedge tckFree);
        o = sharedOe[2] ? sharedOut[2] : 1'bx;
        testClk = 1;
    endtask
    task automatic dr_scan(input logic [8:0] w, output logic [8:0] r);
        logic o;
        step(1, 0, o);
        step(0, 0, o);
        step(0, 0, o);
        for (int i = 0; i < 9; i++) step(i == 8, w[i], r[i]);
        step(1, 0, o);
        step(0, 0, o);
    endtask
    // One bit through the instruction path, read back on the data-out pin
    task automatic ir_scan(input logic d, output logic r);
        logic o;
        step(1, 0, o);
        step(1, 0, o);
        step(0, 0, o);
        step(0, 0, o);
        step(0, d, o);
        step(1, ~d, r);
        step(1, 0, o);
        step(0, 0, o);
    endtask
    // Released pins: mode select left as the last step drove it, data line no longer valid
    task automatic park();
        @(negedge tckFree);
        inFrame = 0;
        tdi = ~tdi;
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the shared scan and probe pin control
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sjp_pkg::*;
    logic core_clk = 0, reset_n = 0, fuseDedicated = 0, fuseProbeDisable = 0, chkUser = 0;
    logic testClk, modeSel, tdi, inFrame, scanActive, probeOutA, probeOeA, probeOutB, probeOeB;
    logic userProbeOutA = 0, userProbeOeA = 0, userProbeOutB = 0, userProbeOeB = 0;
    logic [2:0] sharedOut, sharedOe, userIn;
    sjp_pins_t sharedIn, rndIn = 0, userOut = 0, userOe = 0, prevOut, prevOe;
    sjp_nodes_t probeNodes = 0, prevNodes;
    logic [3:0] prevPrb, expPrb;
    logic [8:0] rdw;
    int n_fail = 0, cmp_count = 0, selA, selB, probeOn = 0;
    wire [3:0] probe_out_b = {probeOeB, probeOutB, probeOeA, probeOutA};
    always #2.5 core_clk = ~core_clk;
    assign sharedIn = {sharedOe[2] ? sharedOut[2] : rndIn[2],
        sharedOe[1] ? sharedOut[1] : (inFrame ? tdi : rndIn[1]), testClk};
    sjp_pin_ctrl i_sjp_pin_ctrl(.*);
    sjp_tester i_sjp_tester(.*);
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (!ok) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Reference of user and probe drive, one core cycle behind
    always @(posedge core_clk) begin
        if (chkUser) check({sharedOut, sharedOe} === {prevOut, prevOe}, "user pins");
        expPrb = (probeOn == 1) ? {1'b1, prevNodes[selB], 1'b1, prevNodes[selA]} : prevPrb;
        if (probeOn != 0) check(probe_out_b === expPrb, "probe pins");
        prevOut = userOut;
        prevOe = userOe;
        prevNodes = probeNodes;
        prevPrb = {userProbeOeB, userProbeOutB, userProbeOeA, userProbeOutA};
        if (reset_n) begin
            userOut <= 3'($urandom);
            userOe <= 3'($urandom);
            rndIn <= 3'($urandom);
            probeNodes <= 16'($urandom);
            {userProbeOeB, userProbeOutB, userProbeOeA, userProbeOutA} <= 4'($urandom);
        end
    end
    task automatic frame(input int m);
        logic o;
        logic [8:0] w;
        logic irIn;
        logic irOut;
        w = {1'b1, 8'($urandom)};
        selA = int'(w[3:0]);
        selB = int'(w[7:4]);
        i_sjp_tester.step(0, 0, o);
        repeat (8) @(posedge core_clk);
        check(scanActive === 1'b1, "scan entry");
        check(sharedOe[1:0] === 2'b00 && userIn === 3'h0, "scan pins");
        i_sjp_tester.dr_scan(w, rdw);
        i_sjp_tester.dr_scan(w, rdw);
        check(rdw === w, "data out word");
        irIn = 1'($urandom);
        i_sjp_tester.ir_scan(irIn, irOut);
        check(irOut === irIn, "instruction bit");
        repeat (8) @(posedge core_clk);
        probeOn <= (m == 2) ? 2 : 1;
        repeat (12) @(posedge core_clk);
        probeOn <= 0;
        i_sjp_tester.step(1, 0, o);
        i_sjp_tester.step(0, 0, o);
        i_sjp_tester.step(0, 0, o);
        repeat (4) i_sjp_tester.step(1, 0, o);
        repeat (10) @(posedge core_clk);
        check(scanActive === 1'b1, "held before logic reset");
        i_sjp_tester.step(1, 0, o);
        i_sjp_tester.park();
        repeat (10) @(posedge core_clk);
        check(scanActive === (m == 1), "release at logic reset");
        chkUser <= (m != 1);
        probeOn <= 2;
        repeat (20) @(posedge core_clk);
    endtask
    initial begin
        void'($urandom(32'hfd1c));
        for (int m = 0; m < 3; m++) begin
            chkUser <= 0;
            probeOn <= 0;
            fuseDedicated <= (m == 1);
            fuseProbeDisable <= (m == 2);
            reset_n <= 0;
            repeat (12) @(posedge core_clk);
            i_sjp_tester.step(1, 0, rdw[0]);
            i_sjp_tester.step(1, 0, rdw[0]);
            i_sjp_tester.park();
            @(posedge core_clk);
            reset_n <= 1;
            repeat (8) @(posedge core_clk);
            check(scanActive === (m == 1), "idle pin mode");
            chkUser <= (m != 1);
            probeOn <= 2;
            repeat (40) @(posedge core_clk);
            chkUser <= 0;
            probeOn <= 0;
            frame(m);
            $display("Mode %0d test done", m);
        end
        end_sim();
    end
    // About seven times the expected run
    initial begin
        #60000;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
endmodule
`default_nettype wire
